// file: asd_defines.svh
// offsets, field positions, reset values and fixed-point constants of the speed/tone/sync block
// assumes 4-bit word-aligned register addresses and the scalings noted beside the a2, y and speed constants
`ifndef ASD_DEFINES_SVH
`define ASD_DEFINES_SVH

`define ASD_ADDR_CTRL 4'h0
`define ASD_ADDR_STATUS 4'h4
`define ASD_ADDR_AVG 4'h8
`define ASD_ADDR_SPEED 4'hC

`define ASD_CTRL_LAW 0
`define ASD_CTRL_EN 1
`define ASD_CTRL_CLR 2
`define ASD_CTRL_RESET 3'h2

// a2 in 2^-14 units: -0.71875
`define ASD_A2_TONE_THR 16'hD200
// y in 2^-9 units: 3.0
`define ASD_Y_IDLE 13'h0600
// speed values in 2^-8 units
`define ASD_AP_ONE 10'h100
`define ASD_AP_STEP 10'h020
// limited speed in 2^-6 units: 1.0
`define ASD_AL_MAX 7'h40
`define ASD_DQTHR_SAT 15'h7C00
`define ASD_PCM_MAG_MAX 7'h7F
`define ASD_MU_CLIP 16'h1FDF
`define ASD_MU_BIAS 16'h0021
`define ASD_A_INV 8'h55
`define ASD_MU_INV 8'h7F
`define ASD_FIFO_DEPTH 8
`define ASD_FIFO_WIDTH 8

`endif

// file: asd_pkg.sv
// types shared by the speed/tone/sync block and its output buffer
// assumes asd_defines.svh for the numeric constants
package asd_pkg;
  typedef enum logic {ASD_LAW_MU, ASD_LAW_A} asd_law_type;
  typedef enum logic [1:0] {ASD_ADJ_KEEP, ASD_ADJ_UP, ASD_ADJ_DOWN} asd_adj_type;
endpackage

// file: asd_stream_if.sv
// valid/ready carrier for pcm words between the block and its buffer
// assumes both ends share ref_clk_i
`timescale 1ns/1ns
interface asd_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: asd_fifo.sv
// small fifo for decoded pcm words, output data held in a register
// assumes a single clock and an asynchronous active-low reset
`timescale 1ns/1ns
module asd_fifo
  import asd_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  asd_stream_if.snk in_if,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  logic load;

  // the output register is a stage of its own, so a full array still lets it refill
  assign in_if.ready = (count_r != (AW+1)'(DEPTH));
  assign push = in_if.valid && in_if.ready;
  assign load = (count_r != '0) && (!out_valid_o || out_ready_i);
  assign pop = load;

  always_ff @(posedge ref_clk_i)
  begin
    if (push)
    begin
      mem_r[wptr_r] <= in_if.data;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_r <= AW'((wptr_r + 1'b1) % DEPTH);
      end
      if (pop)
      begin
        rptr_r <= AW'((rptr_r + 1'b1) % DEPTH);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (load)
    begin
      out_valid_o <= 1'b1;
      out_data_o <= mem_r[rptr_r];
    end
    else if (out_ready_i)
    begin
      out_valid_o <= 1'b0;
    end
  end

  fifo_full_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (count_r == (AW+1)'(DEPTH)) |-> !in_if.ready)
    else $error("fifo accepts while full");
endmodule

// file: asd_top.sv
// speed control, tone detection and decoder pcm adjustment, one sample per strobe
// assumes quantizer, predictor and scale-factor mix run outside and present values with the strobe
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "asd_defines.svh"
module asd_top
  import asd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic sample_stb_i,
  output logic sample_ready_o,
  input wire logic [3:0] code_i,
  input wire logic [15:0] a2_i,
  input wire logic [12:0] y_i,
  input wire logic [18:0] yl_i,
  input wire logic [14:0] dq_mag_i,
  input wire logic [15:0] sr_i,
  input wire logic [15:0] se_i,
  output logic [6:0] al_o,
  output logic td_o,
  output logic tr_o,
  output logic coef_clear_o,
  output logic pcm_valid_o,
  input wire logic pcm_ready_i,
  output logic [7:0] pcm_data_o
);
  logic [2:0] ctrl_r;
  logic [11:0] short_term_avg_r;
  logic [13:0] long_term_avg_r;
  logic [9:0] ap_r;
  logic [6:0] al_r;
  logic td_r;
  logic tr_r;
  logic clear_r;
  logic out_vld_r;
  logic [7:0] out_word_r;
  logic take;
  logic soft_clr;
  asd_stream_if push_if ();

  function automatic logic [3:0] msb_pos(input logic [15:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (v[i])
      begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  function automatic logic [2:0] weight_lookup(input logic [2:0] mag);
    case (mag)
      3'h7: return 3'h7;
      3'h6: return 3'h3;
      3'h5, 3'h4, 3'h3: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  // next pcm level in sign-magnitude form; the zero crossing swaps sign
  function automatic logic [7:0] pcm_step(input logic [7:0] sm, input logic up);
    logic [7:0] r;
    r = sm;
    if (sm[7] == up)
    begin
      if (sm[6:0] != `ASD_PCM_MAG_MAX)
      begin
        r[6:0] = sm[6:0] + 7'h01;
      end
    end
    else if (sm[6:0] != 7'h00)
    begin
      r[6:0] = sm[6:0] - 7'h01;
    end
    else
    begin
      r[7] = up;
    end
    return r;
  endfunction

  assign take = sample_stb_i && sample_ready_o && ctrl_r[`ASD_CTRL_EN];
  assign soft_clr = reg_wr_i && (reg_addr_i == `ASD_ADDR_CTRL) && reg_wdata_i[`ASD_CTRL_CLR];
  // a word still waiting for the buffer stalls the sample source
  assign sample_ready_o = !out_vld_r || push_if.ready;

  // ---------------- speed control ----------------
  logic [2:0] fi;
  logic [11:0] dms_nxt;
  logic [13:0] dml_nxt;
  logic [14:0] avg_dif;
  logic [14:0] avg_abs;
  logic far_apart;
  logic idle;
  logic tone_nxt;
  logic [14:0] dqthr;
  logic [15:0] thr_mant;
  logic tr_nxt;
  logic [9:0] ap_decay;
  logic [9:0] ap_nxt;

  always_comb
  begin
    fi = weight_lookup(code_i[2:0]);
    dms_nxt = 12'(short_term_avg_r + 12'($signed({1'b0, fi, 9'h000}
      - {1'b0, short_term_avg_r}) >>> 5));
    dml_nxt = 14'(long_term_avg_r + 14'($signed({1'b0, fi, 11'h000}
      - {1'b0, long_term_avg_r}) >>> 7));
    avg_dif = {1'b0, dms_nxt, 2'b00} - {1'b0, dml_nxt};
    avg_abs = avg_dif[14] ? 15'(-avg_dif) : avg_dif;
    far_apart = avg_abs >= {4'h0, dml_nxt[13:3]};
    idle = y_i < `ASD_Y_IDLE;
    tone_nxt = $signed(a2_i) < $signed(`ASD_A2_TONE_THR);
    thr_mant = {11'h000, 5'h00} | 16'({1'b1, yl_i[14:10]}) << yl_i[18:15];
    dqthr = (yl_i[18:15] > 4'h9) ? `ASD_DQTHR_SAT :
      15'((thr_mant + (thr_mant >> 1)) >> 1);
    tr_nxt = tone_nxt && (dq_mag_i > dqthr);
    ap_decay = ap_r - (ap_r >> 4);
    if (tr_nxt)
    begin
      ap_nxt = `ASD_AP_ONE;
    end
    else if (far_apart || idle || td_r)
    begin
      ap_nxt = ap_decay + `ASD_AP_STEP;
    end
    else
    begin
      ap_nxt = ap_decay;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      short_term_avg_r <= '0;
      long_term_avg_r <= '0;
      ap_r <= '0;
      al_r <= '0;
    end
    else if (soft_clr)
    begin
      short_term_avg_r <= '0;
      long_term_avg_r <= '0;
      ap_r <= '0;
      al_r <= '0;
    end
    else if (take)
    begin
      short_term_avg_r <= dms_nxt;
      long_term_avg_r <= dml_nxt;
      ap_r <= ap_nxt;
      al_r <= (ap_r > `ASD_AP_ONE) ? `ASD_AL_MAX : ap_r[8:2];
    end
  end

  // ---------------- tone flags ----------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      td_r <= 1'b0;
      tr_r <= 1'b0;
      clear_r <= 1'b0;
    end
    else
    begin
      clear_r <= take && tr_nxt && !soft_clr;
      if (soft_clr)
      begin
        td_r <= 1'b0;
        tr_r <= 1'b0;
      end
      else if (take)
      begin
        td_r <= tone_nxt && !tr_nxt;
        tr_r <= tr_nxt;
      end
    end
  end

  // ---------------- synchronous coding adjustment ----------------
  logic law_a;
  logic neg;
  logic [15:0] mag;
  logic [15:0] x;
  logic [3:0] seg;
  logic [3:0] mant;
  logic [7:0] prov_sm;
  logic [16:0] lin;
  logic [16:0] dx;
  logic [15:0] dx_abs;
  logic [3:0] dx_exp;
  logic [6:0] dx_mant;
  logic [10:0] dl;
  logic signed [12:0] dln;
  logic [2:0] qmag;
  logic signed [3:0] new_lv;
  logic signed [3:0] rx_lv;
  asd_adj_type adj;
  logic [7:0] fin_sm;

  always_comb
  begin
    law_a = ctrl_r[`ASD_CTRL_LAW] == ASD_LAW_A;
    neg = sr_i[15];
    mag = neg ? 16'(-sr_i) : sr_i;
    // pcm_compressor the reconstructed signal to a provisional code
    if (!law_a)
    begin
      x = ((mag > `ASD_MU_CLIP) ? `ASD_MU_CLIP : mag) + `ASD_MU_BIAS;
      seg = 4'(msb_pos(x) - 4'h5);
      mant = 4'(x >> (seg + 4'h1));
    end
    else
    begin
      x = (mag[15:1] > 15'h0FFF) ? 16'h0FFF : {1'b0, mag[15:1]};
      seg = (x < 16'h0020) ? 4'h0 : 4'(msb_pos(x) - 4'h4);
      mant = (x < 16'h0020) ? 4'(x >> 1) : 4'(x >> seg);
    end
    prov_sm = {!neg, seg[2:0], mant};
    // expand the provisional code back to linear form
    if (!law_a)
    begin
      lin = 17'((({13'h0000, prov_sm[3:0], 1'b0} + 17'h00021) << prov_sm[6:4]) - 17'h00021);
    end
    else if (prov_sm[6:4] == 3'h0)
    begin
      lin = 17'(({12'h000, prov_sm[3:0], 1'b0} + 17'h00001) << 1);
    end
    else
    begin
      lin = 17'(({12'h000, prov_sm[3:0], 1'b0} + 17'h00021) << prov_sm[6:4]);
    end
    if (!prov_sm[7])
    begin
      lin = 17'(-lin);
    end
    dx = 17'(lin - {se_i[15], se_i});
    dx_abs = dx[16] ? 16'(-dx) : dx[15:0];
    dx_exp = msb_pos(dx_abs);
    dx_mant = 7'(({dx_abs, 7'h00}) >> dx_exp);
    dl = {dx_exp, dx_mant};
    dln = $signed({2'b00, dl}) - $signed({2'b00, y_i[12:2]});
    if (dln >= 13'sd400) qmag = 3'h7;
    else if (dln >= 13'sd349) qmag = 3'h6;
    else if (dln >= 13'sd300) qmag = 3'h5;
    else if (dln >= 13'sd246) qmag = 3'h4;
    else if (dln >= 13'sd178) qmag = 3'h3;
    else if (dln >= 13'sd80) qmag = 3'h2;
    else if (dln >= -13'sd124) qmag = 3'h1;
    else qmag = 3'h0;
    new_lv = dx[16] ? -$signed({1'b0, qmag}) : $signed({1'b0, qmag});
    rx_lv = code_i[3] ? -$signed({1'b0, code_i[2:0]}) : $signed({1'b0, code_i[2:0]});
    if (new_lv < rx_lv)
    begin
      adj = ASD_ADJ_UP;
    end
    else if (new_lv > rx_lv)
    begin
      adj = ASD_ADJ_DOWN;
    end
    else
    begin
      adj = ASD_ADJ_KEEP;
    end
    case (adj)
      ASD_ADJ_UP: fin_sm = pcm_step(prov_sm, 1'b1);
      ASD_ADJ_DOWN: fin_sm = pcm_step(prov_sm, 1'b0);
      default: fin_sm = prov_sm;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_vld_r <= 1'b0;
      out_word_r <= '0;
    end
    else if (take)
    begin
      out_vld_r <= 1'b1;
      // mu-law sends the sign as is and inverts only the magnitude
      out_word_r <= law_a ? (fin_sm ^ `ASD_A_INV) : (fin_sm ^ `ASD_MU_INV);
    end
    else if (push_if.ready)
    begin
      out_vld_r <= 1'b0;
    end
  end

  assign push_if.valid = out_vld_r;
  assign push_if.data = out_word_r;

  asd_fifo #(
    .WIDTH(`ASD_FIFO_WIDTH),
    .DEPTH(`ASD_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_if(push_if),
    .out_valid_o(pcm_valid_o),
    .out_ready_i(pcm_ready_i),
    .out_data_o(pcm_data_o)
  );

  // ---------------- registers ----------------
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r <= `ASD_CTRL_RESET;
    end
    else if (reg_wr_i && (reg_addr_i == `ASD_ADDR_CTRL))
    begin
      // the clear bit is a pulse and never stays set
      ctrl_r <= {1'b0, reg_wdata_i[1:0]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_rd_i)
    begin
      if (reg_addr_i == `ASD_ADDR_CTRL)
        reg_rdata_o <= {29'h0, ctrl_r};
      else if (reg_addr_i == `ASD_ADDR_STATUS)
        reg_rdata_o <= {23'h0, tr_r, td_r, al_r};
      else if (reg_addr_i == `ASD_ADDR_AVG)
        reg_rdata_o <= {2'h0, long_term_avg_r, 4'h0, short_term_avg_r};
      else if (reg_addr_i == `ASD_ADDR_SPEED)
        reg_rdata_o <= {22'h0, ap_r};
      else
        reg_rdata_o <= '0;
    end
    else
    begin
      reg_rdata_o <= '0;
    end
  end

  assign al_o = al_r;
  assign td_o = td_r;
  assign tr_o = tr_r;
  assign coef_clear_o = clear_r;

  tr_loads_one_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && tr_nxt && !soft_clr |=> ap_r == `ASD_AP_ONE)
    else $error("transition did not load speed one");
  speed_clamp_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && !soft_clr && ap_r > `ASD_AP_ONE |=> al_r == `ASD_AL_MAX)
    else $error("limited speed not clamped");
  idle_step_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && !soft_clr && !tr_nxt && idle |=>
      ap_r == 10'($past(ap_r) - ($past(ap_r) >> 4) + `ASD_AP_STEP))
    else $error("idle channel step missing");
  tone_flag_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && !soft_clr && !tr_nxt |=> td_r == ($signed($past(a2_i)) < $signed(`ASD_A2_TONE_THR)))
    else $error("tone flag wrong");
  coef_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && tr_nxt && !soft_clr |=> coef_clear_o && !td_r)
    else $error("transition did not clear");
  clear_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    coef_clear_o |-> $past(take && tr_nxt && !soft_clr))
    else $error("coefficient clear without transition");
  state_hold_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !take && !soft_clr |=> $stable(ap_r) && $stable(short_term_avg_r) && $stable(td_r))
    else $error("state moved without strobe");
  avg_rise_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && !soft_clr && code_i[2:0] == 3'h7 && short_term_avg_r < 12'hC00 |=>
      short_term_avg_r > $past(short_term_avg_r))
    else $error("short average did not rise");
  clear_all_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    soft_clr |=> ap_r == '0 && long_term_avg_r == '0 && !td_r && !tr_r)
    else $error("clear left state behind");
  adjust_up_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    take && adj == ASD_ADJ_UP && prov_sm[7] && prov_sm[6:0] != 7'h7F && !law_a |=>
      out_word_r == (($past(prov_sm) + 8'h01) ^ `ASD_MU_INV))
    else $error("pcm not stepped up");
endmodule

// file: asd_pcm_sink.sv
// pcm word sink standing at the block's output, counts accepted words
// assumes the shared clock and active-low reset; stalls on request of the bench
`timescale 1ns/1ns
module asd_pcm_sink
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic pcm_valid_i,
  input wire logic stall_i,
  output logic pcm_ready_o,
  output int words_o
);
  // ready is registered, so a stall lands one cycle late like a real sink
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pcm_ready_o <= 1'b0;
      words_o <= 0;
    end
    else
    begin
      pcm_ready_o <= !stall_i;
      if (pcm_valid_i && pcm_ready_o)
        words_o <= words_o + 1;
    end
  end
endmodule

// file: asd_top_tb.sv
// self-checking bench of the speed/tone/sync block, one task per scenario
// assumes asd_defines.svh constants and the sink model at the pcm output
`timescale 1ns/1ns
`include "asd_defines.svh"
module asd_top_tb;
  import asd_pkg::*;
  logic ref_clk_i, resetn_i, reg_wr_i, reg_rd_i, sample_stb_i, pcm_ready_i, stall;
  logic [3:0] reg_addr_i, code_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [15:0] a2_i;
  logic [12:0] y_i;
  logic [14:0] dq_mag_i;
  logic [15:0] sr_i, se_i;
  logic [18:0] yl_i;
  logic sample_ready_o, td_o, tr_o, coef_clear_o, pcm_valid_o;
  logic [6:0] al_o;
  logic [7:0] pcm_data_o;
  int err_count, cmp_count, words;
  logic [31:0] wt [8] = '{0, 0, 0, 1, 1, 1, 3, 7};

  asd_top uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sample_stb_i(sample_stb_i), .sample_ready_o(sample_ready_o),
    .code_i(code_i), .a2_i(a2_i), .y_i(y_i), .yl_i(yl_i), .dq_mag_i(dq_mag_i),
    .sr_i(sr_i), .se_i(se_i), .al_o(al_o), .td_o(td_o), .tr_o(tr_o),
    .coef_clear_o(coef_clear_o), .pcm_valid_o(pcm_valid_o), .pcm_ready_i(pcm_ready_i),
    .pcm_data_o(pcm_data_o));

  asd_pcm_sink sink (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .pcm_valid_i(pcm_valid_o),
    .stall_i(stall), .pcm_ready_o(pcm_ready_i), .words_o(words));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic reg_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
  endtask

  task automatic send(input logic [3:0] c, input logic [15:0] a2, input logic [12:0] y,
    input logic [14:0] dq);
    int i;
    i = 0;
    while (sample_ready_o !== 1'b1 && i < 50)
    begin
      @(posedge ref_clk_i);
      #1;
      i++;
    end
    if (i == 50)
      chk(sample_ready_o, 1'b1);
    @(posedge ref_clk_i);
    code_i <= c;
    a2_i <= a2;
    y_i <= y;
    dq_mag_i <= dq;
    sample_stb_i <= 1'b1;
    @(posedge ref_clk_i);
    sample_stb_i <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    reg_chk(`ASD_ADDR_CTRL, 32'h00000002);
    reg_chk(`ASD_ADDR_STATUS, 32'h00000000);
    reg_chk(`ASD_ADDR_AVG, 32'h00000000);
    reg_chk(`ASD_ADDR_SPEED, 32'h00000000);
    reg_chk(4'h2, 32'h00000000);
    reg_wr(`ASD_ADDR_STATUS, 32'h000001FF);
    reg_chk(`ASD_ADDR_STATUS, 32'h00000000);
    reg_wr(`ASD_ADDR_CTRL, 32'h00000003);
    reg_chk(`ASD_ADDR_CTRL, 32'h00000003);
  endtask

  // the all-zero word is never sent: magnitude 0 goes out with the sign set
  task automatic t_avg();
    for (int m = 0; m < 8; m++)
    begin
      reg_wr(`ASD_ADDR_CTRL, 32'h00000006);
      send({m == 0, 3'(m)}, 16'h0000, 13'h0600, 15'h0000);
      reg_chk(`ASD_ADDR_AVG, (wt[m] << 20) | (wt[m] << 4));
    end
    send(4'h7, 16'h0000, 13'h0600, 15'h0000);
    reg_chk(`ASD_ADDR_AVG, 32'h00DF00DC);
  endtask

  task automatic t_speed();
    reg_wr(`ASD_ADDR_CTRL, 32'h00000006);
    send(4'h8, 16'h0000, 13'h0000, 15'h0000);
    reg_chk(`ASD_ADDR_SPEED, 32'h00000020);
    chk(al_o, 7'h00);
    send(4'h8, 16'h0000, 13'h0000, 15'h0000);
    reg_chk(`ASD_ADDR_SPEED, 32'h0000003E);
    chk(al_o, 7'h08);
  endtask

  task automatic t_tone();
    send(4'h8, `ASD_A2_TONE_THR, 13'h0600, 15'h0000);
    chk(td_o, 1'b0);
    send(4'h8, 16'hD1FF, 13'h0600, 15'h0000);
    chk(td_o, 1'b1);
    chk(tr_o, 1'b0);
    send(4'h8, 16'h8000, 13'h0600, 15'h0000);
    chk(td_o, 1'b1);
    // slow scale 1.0 doubles the threshold to 48, so 40 is no transition
    @(posedge ref_clk_i);
    yl_i <= 19'h08000;
    send(4'h8, 16'h8000, 13'h0600, 15'h0028);
    chk(tr_o, 1'b0);
    @(posedge ref_clk_i);
    yl_i <= 19'h00000;
  endtask

  // a transition forces speed to one; next samples see one, then the clamp
  task automatic t_tone_change_check();
    send(4'h8, 16'hD1FF, 13'h0600, 15'h7FFF);
    chk(tr_o, 1'b1);
    chk(td_o, 1'b0);
    chk(coef_clear_o, 1'b1);
    @(posedge ref_clk_i);
    #1;
    chk(coef_clear_o, 1'b0);
    reg_chk(`ASD_ADDR_SPEED, 32'h00000100);
    send(4'h8, 16'h0000, 13'h0000, 15'h0000);
    chk(tr_o, 1'b0);
    chk(al_o, `ASD_AL_MAX);
    reg_chk(`ASD_ADDR_SPEED, 32'h00000110);
    send(4'h8, 16'h0000, 13'h0000, 15'h0000);
    chk(al_o, `ASD_AL_MAX);
    reg_chk(`ASD_ADDR_STATUS, 32'h00000040);
  endtask

  task automatic t_clear();
    reg_wr(`ASD_ADDR_CTRL, 32'h00000006);
    reg_chk(`ASD_ADDR_SPEED, 32'h00000000);
    reg_chk(`ASD_ADDR_STATUS, 32'h00000000);
    reg_chk(`ASD_ADDR_AVG, 32'h00000000);
    reg_chk(`ASD_ADDR_CTRL, 32'h00000002);
  endtask

  // with enable low a strobe must leave state and output untouched
  task automatic t_refuse();
    int w0;
    reg_wr(`ASD_ADDR_CTRL, 32'h00000000);
    repeat (6) @(posedge ref_clk_i);
    w0 = words;
    send(4'hF, 16'h8000, 13'h0000, 15'h7FFF);
    repeat (6) @(posedge ref_clk_i);
    #1;
    chk(pcm_valid_o, 1'b0);
    chk(words - w0, 0);
    chk(tr_o, 1'b0);
    reg_chk(`ASD_ADDR_SPEED, 32'h00000000);
    reg_wr(`ASD_ADDR_CTRL, 32'h00000002);
  endtask

  // one decoded word from the given reconstruction and estimate, judged as it leaves
  task automatic sync_one(input logic [3:0] c, input logic [15:0] sr, input logic [15:0] se,
    input logic [7:0] exp);
    int i;
    i = 0;
    @(posedge ref_clk_i);
    sr_i <= sr;
    se_i <= se;
    send(c, 16'h0000, 13'h0600, 15'h0000);
    while (!(pcm_valid_o === 1'b1 && pcm_ready_i === 1'b1) && i < 20)
    begin
      @(negedge ref_clk_i);
      i++;
    end
    chk({pcm_valid_o, pcm_data_o}, {1'b1, exp});
  endtask

  // zero and 256 at scale 3.0: the re-quantized level is compared with the code
  task automatic t_sync();
    sync_one(4'h8, 16'h0000, 16'h0000, 8'hFF);
    sync_one(4'h1, 16'h0000, 16'h0000, 8'hFE);
    sync_one(4'h9, 16'h0000, 16'h0000, 8'h7F);
    sync_one(4'hF, 16'h0000, 16'h0100, 8'hFF);
    sync_one(4'h1, 16'h0100, 16'h0100, 8'hCD);
    sync_one(4'h8, 16'h0100, 16'h0100, 8'hCE);
    reg_wr(`ASD_ADDR_CTRL, 32'h00000003);
    sync_one(4'h8, 16'h0000, 16'h0000, 8'hD5);
    sync_one(4'h1, 16'h0000, 16'h0000, 8'hD4);
    sync_one(4'h9, 16'h0000, 16'h0000, 8'h55);
    reg_wr(`ASD_ADDR_CTRL, 32'h00000002);
  endtask

  // buffer of eight, its output stage and the word ahead of it make ten
  task automatic t_fifo();
    int n, i, w0;
    n = 0;
    stall <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    w0 = words;
    @(posedge ref_clk_i);
    code_i <= 4'h9;
    sample_stb_i <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(negedge ref_clk_i);
      if (sample_ready_o !== 1'b1)
        break;
      n++;
      @(posedge ref_clk_i);
    end
    @(posedge ref_clk_i);
    sample_stb_i <= 1'b0;
    #1;
    chk(n, `ASD_FIFO_DEPTH + 2);
    chk(sample_ready_o, 1'b0);
    stall <= 1'b0;
    i = 0;
    while (words - w0 < n && i < 200)
    begin
      @(posedge ref_clk_i);
      i++;
    end
    repeat (4) @(posedge ref_clk_i);
    #1;
    chk(words - w0, n);
    chk(pcm_valid_o, 1'b0);
  endtask

  initial
  begin
    err_count = 0;
    cmp_count = 0;
    resetn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h00000000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    sample_stb_i = 1'b0;
    code_i = 4'h8;
    a2_i = 16'h0000;
    y_i = 13'h0600;
    dq_mag_i = 15'h0000;
    sr_i = 16'h0000;
    se_i = 16'h0000;
    yl_i = 19'h00000;
    stall = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_avg();
    t_speed();
    t_tone();
    t_tone_change_check();
    t_clear();
    t_refuse();
    t_sync();
    t_fifo();
    conclude();
  end

  // the whole sequence needs well under 2000 cycles
  initial
  begin
    #40000;
    err_count++;
    conclude();
  end
endmodule
